//--- seswp_core.sv
// Purpose: write latch, status register and write guarding of a serial eeprom
// Assumes: serial clock mode 0, clk much faster than the serial clock
// Notes: serial logic runs on the serial clock; its counters, shift register and output are reset by deselection
`timescale 1ns/100ps
`include "seswp_regs.svh"

module seswp_core #(
  parameter int unsigned WriteCycleNs = 1000  // self-timed write cycle in ns
) (
  input  wire logic                       clk,          // system clock
  input  wire logic                       rst_n,        // async reset, low
  input  wire logic                       serialClk,    // serial link clock
  input  wire logic                       selectN,      // chip select, low
  input  wire logic                       serialIn,     // serial data in
  output logic                            serialOut,    // serial data out
  output logic                            serialOeN,    // out enable, low
  input  wire logic                       writeGuardN,  // write guard pin
  input  wire seswp_pkg::seswp_arrreq_type arrReq,      // array write request
  output logic                            arrAck,       // array write taken
  output logic                            arrNak,       // array write refused
  output seswp_pkg::seswp_status_type     statusOut     // status byte
);

  localparam logic [31:0] WcRaw =
    32'((WriteCycleNs + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [31:0] WcCycles = (WcRaw == 32'h0) ? 32'h1 : WcRaw;

  // serial side state
  logic [4:0]                  cntR, cntNxt;
  logic [2:0]                  phaseR, phaseNxt;
  logic [7:0]                  shR, shNxt;
  logic [7:0]                  snapR, snapNxt;
  logic [7:0]                  opR, opNxt;
  logic [7:0]                  dataR, dataNxt;
  seswp_pkg::seswp_code_type   codeR, codeNxt;
  logic                        tglR, tglNxt;
  logic [7:0]                  stS1R, stS2R;
  logic                        outR, outNxt;
  logic                        oeNR, oeNNxt;

  // system side state
  logic                        csS1R, csS2R, csS3R;
  logic                        wgS1R, wgS2R;
  logic                        tgS1R, tgS2R;
  logic                        seenR, seenNxt;
  seswp_pkg::seswp_state_type  stateR, stateNxt;
  seswp_pkg::seswp_status_type statR, statNxt;
  logic [31:0]                 timerR, timerNxt;
  logic [7:0]                  pendR, pendNxt;
  logic                        ackR, ackNxt;
  logic                        nakR, nakNxt;
  logic                        csRise;
  logic                        fresh;
  logic                        hwLock;
  logic                        guarded;
  logic                        cmdNow;

  // ---------------- serial clock domain ----------------

  // shift register and bit counters, cleared while deselected
  always_comb begin
    shNxt    = {shR[6:0], serialIn};
    cntNxt   = (cntR == `BIT_SAT) ? cntR : cntR + 5'h01;
    phaseNxt = phaseR + 3'h1;
    snapNxt  = (phaseR == `PHASE_LAST) ? stS2R : snapR;
  end

  always_ff @(posedge serialClk or posedge selectN) begin
    if (selectN) begin
      cntR   <= `BIT_FIRST;
      phaseR <= 3'h0;
      shR    <= 8'h00;
      snapR  <= 8'h00;
    end else begin
      cntR   <= cntNxt;
      phaseR <= phaseNxt;
      shR    <= shNxt;
      snapR  <= snapNxt;
    end
  end

  // decoded command of the frame, held for the system side after deselect
  always_comb begin
    opNxt   = opR;
    codeNxt = codeR;
    dataNxt = dataR;
    tglNxt  = tglR;
    if (cntR == `BIT_FIRST) begin
      codeNxt = seswp_pkg::CODE_NONE;
      tglNxt  = ~tglR;
    end
    if (cntR == `BIT_LAST_OP) begin
      opNxt = shNxt;
      case (shNxt)
        `OP_SET_LATCH: codeNxt = seswp_pkg::CODE_SET;
        `OP_CLR_LATCH: codeNxt = seswp_pkg::CODE_CLR;
        default:       codeNxt = seswp_pkg::CODE_NONE;
      endcase
    end
    if (cntR == `BIT_LAST_DATA && opR == `OP_STATUS_WR) begin
      codeNxt = seswp_pkg::CODE_SWR;
      dataNxt = shNxt;
    end
    if (cntR == `BIT_OVER && opR == `OP_STATUS_WR) begin
      codeNxt = seswp_pkg::CODE_NONE;
    end
  end

  always_ff @(posedge serialClk or negedge rst_n) begin
    if (!rst_n) begin
      opR   <= 8'h00;
      codeR <= seswp_pkg::CODE_NONE;
      dataR <= 8'h00;
      tglR  <= 1'b0;
    end else begin
      opR   <= opNxt;
      codeR <= codeNxt;
      dataR <= dataNxt;
      tglR  <= tglNxt;
    end
  end

  // status byte brought over bit by bit; guard is a two-bit field, and several bits can change in the same clk cycle
  always_ff @(posedge serialClk or negedge rst_n) begin
    if (!rst_n) begin
      stS1R <= `STATUS_RESET;
      stS2R <= `STATUS_RESET;
    end else begin
      stS1R <= statR;
      stS2R <= stS1R;
    end
  end

  // output shifts on the falling edge, released while deselected
  always_comb begin
    outNxt = 1'b0;
    oeNNxt = 1'b1;
    if (opR == `OP_STATUS_RD && cntR >= `BIT_OP_DONE) begin
      outNxt = snapR[`PHASE_LAST - phaseR];
      oeNNxt = 1'b0;
    end
  end

  always_ff @(negedge serialClk or posedge selectN) begin
    if (selectN) begin
      outR <= 1'b0;
      oeNR <= 1'b1;
    end else begin
      outR <= outNxt;
      oeNR <= oeNNxt;
    end
  end

  assign serialOut = outR;
  assign serialOeN = oeNR;

  // ---------------- system clock domain ----------------

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csS1R <= 1'b1;
      csS2R <= 1'b1;
      csS3R <= 1'b1;
      wgS1R <= 1'b1;
      wgS2R <= 1'b1;
      tgS1R <= 1'b0;
      tgS2R <= 1'b0;
    end else begin
      csS1R <= selectN;
      csS2R <= csS1R;
      csS3R <= csS2R;
      wgS1R <= writeGuardN;
      wgS2R <= wgS1R;
      tgS1R <= tglR;
      tgS2R <= tgS1R;
    end
  end

  always_comb begin
    csRise = csS2R & ~csS3R;
    // a frame with no clock edges leaves the old code stale
    fresh  = tgS2R != seenR;
    hwLock = statR.lockBit & ~wgS2R;
    cmdNow = csRise & fresh;
    case (statR.guard)
      `GUARD_NONE:    guarded = 1'b0;
      `GUARD_QUARTER: guarded = arrReq.addr >= `BASE_QUARTER;
      `GUARD_HALF:    guarded = arrReq.addr >= `BASE_HALF;
      default:        guarded = 1'b1;
    endcase
  end

  always_comb begin
    stateNxt = stateR;
    statNxt  = statR;
    timerNxt = timerR;
    pendNxt  = pendR;
    seenNxt  = csRise ? tgS2R : seenR;
    ackNxt   = 1'b0;
    nakNxt   = 1'b0;
    statNxt.rsvd = 3'h0;
    case (stateR)
      seswp_pkg::ST_IDLE: begin
        if (cmdNow) begin
          case (codeR)
            seswp_pkg::CODE_SET: statNxt.writeLatch = 1'b1;
            seswp_pkg::CODE_CLR: statNxt.writeLatch = 1'b0;
            seswp_pkg::CODE_SWR: begin
              if (statR.writeLatch && !hwLock) begin
                stateNxt    = seswp_pkg::ST_STATUS_WR;
                pendNxt     = dataR;
                timerNxt    = WcCycles;
                statNxt.busy = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
        if (arrReq.req && !cmdNow) begin
          if (statR.writeLatch && !guarded) begin
            stateNxt     = seswp_pkg::ST_ARRAY_WR;
            timerNxt     = WcCycles;
            statNxt.busy = 1'b1;
            ackNxt       = 1'b1;
          end else begin
            nakNxt = 1'b1;
          end
        end else if (arrReq.req) begin
          nakNxt = 1'b1;
        end
      end
      seswp_pkg::ST_STATUS_WR: begin
        nakNxt = arrReq.req;
        if (timerR == 32'h1) begin
          stateNxt           = seswp_pkg::ST_IDLE;
          // only lock and guard bits taken
          statNxt.lockBit    = pendR[`WR_LOCK_POS];
          statNxt.guard      = pendR[`WR_GUARD_HI:`WR_GUARD_LO];
          statNxt.writeLatch = 1'b0;
          statNxt.busy       = 1'b0;
        end else begin
          timerNxt = timerR - 32'h1;
        end
      end
      seswp_pkg::ST_ARRAY_WR: begin
        nakNxt = arrReq.req;
        if (timerR == 32'h1) begin
          stateNxt           = seswp_pkg::ST_IDLE;
          statNxt.writeLatch = 1'b0;
          statNxt.busy       = 1'b0;
        end else begin
          timerNxt = timerR - 32'h1;
        end
      end
      default: begin
        stateNxt     = seswp_pkg::ST_IDLE;
        statNxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateR <= seswp_pkg::ST_IDLE;
      statR  <= `STATUS_RESET;
      timerR <= 32'h0;
      pendR  <= 8'h00;
      seenR  <= 1'b0;
      ackR   <= 1'b0;
      nakR   <= 1'b0;
    end else begin
      stateR <= stateNxt;
      statR  <= statNxt;
      timerR <= timerNxt;
      pendR  <= pendNxt;
      seenR  <= seenNxt;
      ackR   <= ackNxt;
      nakR   <= nakNxt;
    end
  end

  assign arrAck    = ackR;
  assign arrNak    = nakR;
  assign statusOut = statR;

  // ---------------- checks ----------------

  a_busy_state: assert property (
    @(posedge clk) disable iff (!rst_n)
    statR.busy == (stateR != seswp_pkg::ST_IDLE))
    else $error("busy flag disagrees with write cycle state");

  a_set_latch: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmdNow && codeR == seswp_pkg::CODE_SET && stateR == seswp_pkg::ST_IDLE
    |=> statR.writeLatch)
    else $error("set-latch command did not set the latch");

  a_clear_latch: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmdNow && codeR == seswp_pkg::CODE_CLR && stateR == seswp_pkg::ST_IDLE
    |=> !statR.writeLatch)
    else $error("clear-latch command did not clear the latch");

  a_cycle_end_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    stateR != seswp_pkg::ST_IDLE && timerR == 32'h1
    |=> stateR == seswp_pkg::ST_IDLE && !statR.writeLatch && !statR.busy)
    else $error("write cycle end left latch or busy set");

  a_start_needs_latch: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(statR.busy) |-> $past(statR.writeLatch))
    else $error("write cycle started with latch clear");

  a_hw_lock_refuse: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmdNow && codeR == seswp_pkg::CODE_SWR && hwLock && stateR == seswp_pkg::ST_IDLE
    |=> stateR == seswp_pkg::ST_IDLE ##1 stateR == seswp_pkg::ST_IDLE)
    else $error("status write taken in hardware lock mode");

  a_guard_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    stateR == seswp_pkg::ST_STATUS_WR && timerR != 32'h1
    |=> $stable(statR.guard) && $stable(statR.lockBit))
    else $error("guard bits changed before the cycle ended");

  a_guard_refuse: assert property (
    @(posedge clk) disable iff (!rst_n)
    arrReq.req && guarded |=> !arrAck && arrNak)
    else $error("array write into guarded region was taken");

  a_cycle_length: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(stateR == seswp_pkg::ST_STATUS_WR) |-> timerR == WcCycles)
    else $error("status write cycle length wrong");

  a_reserved_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    stateR == seswp_pkg::ST_STATUS_WR |=> statR.rsvd == 3'h0)
    else $error("reserved status bits not zero");

endmodule // seswp_core

//--- seswp_core_test.sv
// Purpose: self-checking bench of the status and write-guard block
// Assumes: one serial host, write cycle shortened to 400 clk
// Notes: opcodes 06h, 04h, 05h, 01h are all sent
`timescale 1ns/100ps

module seswp_core_test;
  logic                        clk;
  logic                        rst_n;
  logic                        writeGuardN;
  logic                        serialClk;
  logic                        selectN;
  logic                        serialIn;
  logic                        serialOut;
  logic                        serialOeN;
  logic                        arrAck;
  logic                        arrNak;
  seswp_pkg::seswp_arrreq_type arrReq;
  seswp_pkg::seswp_status_type statusOut;
  logic [15:0]                 rx;
  logic [14:0]                 addrs [5];
  int                          errors;
  int                          nTests;
  int                          oeLow;

  seswp_core #(.WriteCycleNs(4000)) u_dut (
    .clk(clk), .rst_n(rst_n), .serialClk(serialClk), .selectN(selectN),
    .serialIn(serialIn), .serialOut(serialOut), .serialOeN(serialOeN),
    .writeGuardN(writeGuardN), .arrReq(arrReq), .arrAck(arrAck), .arrNak(arrNak),
    .statusOut(statusOut)
  );

  seswp_host_model u_host (
    .serialClk(serialClk), .selectN(selectN), .serialIn(serialIn), .serialOut(serialOut)
  );

  // counts serial rises that see the output enabled
  always @(posedge serialClk) begin
    if (serialOeN === 1'b0) begin
      oeLow <= oeLow + 1;
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic testDone;
    $display("checks=%0d mismatches=%0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] op, input logic [15:0] dat, input int nDat);
    u_host.xfer(op, dat, nDat, rx);
    settle();
  endtask

  task automatic waitIdle;
    int n;
    n = 0;
    while (statusOut.busy !== 1'b0 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 1000) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
      testDone();
    end
  endtask

  // latch, write, then expect a cycle or not
  task automatic swr(input logic [7:0] d, input logic ok);
    cmd(8'h06, 16'h0000, 0);
    cmd(8'h01, {d, 8'h00}, 8);
    check({7'h00, statusOut.busy}, {7'h00, ok});
    waitIdle();
  endtask

  task automatic probe(input logic [14:0] a, input logic nak);
    @(posedge clk);
    #1 arrReq = '{req: 1'b1, addr: a};
    @(posedge clk);
    #1 arrReq.req = 1'b0;
    check({6'h00, arrAck, arrNak}, {6'h00, ~nak, nak});
  endtask

  function automatic logic guarded(input logic [1:0] g, input logic [14:0] a);
    case (g)
      2'h0: return 1'b0;
      2'h1: return a >= 15'h6000;
      2'h2: return a >= 15'h4000;
      default: return 1'b1;
    endcase
  endfunction

  initial begin
    errors = 0;
    nTests = 0;
    rst_n = 1'b0;
    writeGuardN = 1'b1;
    arrReq = '0;
    addrs = '{15'h3FFF, 15'h4000, 15'h5FFF, 15'h6000, 15'h7FFF};
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(statusOut, 8'h00);
    probe(15'h0000, 1'b1);
    cmd(8'h06, 16'h0400, 8);
    check(statusOut, 8'h02);
    cmd(8'h04, 16'h0000, 0);
    check(statusOut, 8'h00);
    cmd(8'h07, 16'h0000, 0);
    check(statusOut, 8'h00);
    cmd(8'h06, 16'h0000, 0);
    cmd(8'h01, 16'h8C00, 9);
    check(statusOut, 8'h02);
    cmd(8'h01, 16'h8C00, 7);
    check(statusOut, 8'h02);
    cmd(8'h01, 16'hFF00, 8);
    u_host.xfer(8'h05, 16'h0000, 16, rx);
    check(rx[15:8], 8'h03);
    check(rx[7:0], 8'h03);
    check({6'h00, serialOut, serialOeN}, 8'h01);
    check({6'h00, statusOut.guard}, 8'h00);
    probe(15'h0000, 1'b1);
    waitIdle();
    check(statusOut, 8'h8C);
    for (int g = 0; g < 4; g++) begin
      swr({1'b0, 3'h7, g[1:0], 2'h3}, 1'b1);
      check(statusOut, {4'h0, g[1:0], 2'h0});
      cmd(8'h06, 16'h0000, 0);
      foreach (addrs[i]) begin
        probe(addrs[i], guarded(g[1:0], addrs[i]));
        if (!guarded(g[1:0], addrs[i])) begin
          waitIdle();
          check(statusOut, {4'h0, g[1:0], 2'h0});
          cmd(8'h06, 16'h0000, 0);
        end
      end
    end
    swr(8'h84, 1'b1);
    check(statusOut, 8'h84);
    writeGuardN = 1'b0;
    settle();
    swr(8'h00, 1'b0);
    check(statusOut, 8'h86);
    writeGuardN = 1'b1;
    settle();
    swr(8'h00, 1'b1);
    check(statusOut, 8'h00);
    writeGuardN = 1'b0;
    settle();
    swr(8'h88, 1'b1);
    check(statusOut, 8'h88);
    swr(8'h00, 1'b0);
    check(statusOut, 8'h8A);
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(statusOut, 8'h00);
    writeGuardN = 1'b1;
    settle();
    swr(8'h00, 1'b1);
    check(statusOut, 8'h00);
    check(8'(oeLow), 8'h10);
    testDone();
  end
endmodule // seswp_core_test

//--- seswp_host_model.sv
// Purpose: serial host that frames commands for the status and write-guard block
// Assumes: serial clock mode 0, clock low and still between frames
// Notes: deselects in the high half of the last bit
`timescale 1ns/100ps

module seswp_host_model (
  output logic      serialClk,  // serial clock
  output logic      selectN,    // chip select, low
  output logic      serialIn,   // data to device
  input  wire logic serialOut   // data from device
);
  localparam time HalfBit = 40;

  initial begin
    serialClk = 1'b0;
    selectN   = 1'b1;
    serialIn  = 1'b1;
  end

  // opcode, then nDat bits of dat from its msb; rx collects bits after the opcode
  task automatic xfer(input logic [7:0] op, input logic [15:0] dat, input int nDat,
                      output logic [15:0] rx);
    logic [23:0] bits;
    bits = {op, dat};
    rx = 16'h0000;
    #3;
    selectN = 1'b0;
    for (int i = 0; i < 8 + nDat; i++) begin
      if (i > 0) begin
        #(HalfBit / 2);
      end
      serialClk = 1'b0;
      serialIn = bits[23 - i];
      #HalfBit;
      serialClk = 1'b1;
      if (i >= 8) begin
        rx = {rx[14:0], serialOut};
      end
      #(HalfBit / 2);
    end
    selectN = 1'b1;
    #(HalfBit / 2);
    serialClk = 1'b0;
    // released line does not keep its last level
    serialIn = ~serialIn;
  endtask
endmodule // seswp_host_model

//--- seswp_pkg.sv
// Purpose: shared types of the serial eeprom status and write-guard block
// Assumes: nothing
// Notes: status struct order is the status byte bit order, msb first
package seswp_pkg;

  typedef struct packed {
    logic       lockBit;
    logic [2:0] rsvd;
    logic [1:0] guard;
    logic       writeLatch;
    logic       busy;
  } seswp_status_type;

  typedef struct packed {
    logic        req;
    logic [14:0] addr;
  } seswp_arrreq_type;

  typedef enum logic [1:0] {
    CODE_NONE,
    CODE_SET,
    CODE_CLR,
    CODE_SWR
  } seswp_code_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STATUS_WR,
    ST_ARRAY_WR
  } seswp_state_type;

endpackage

//--- seswp_regs.svh
// Purpose: constants of the serial eeprom status and write-guard block
// Assumes: included by its bare name
// Notes: definitions only
`ifndef SESWP_REGS_SVH
`define SESWP_REGS_SVH

// command opcodes, msb first on the wire
`define OP_SET_LATCH   8'h06
`define OP_CLR_LATCH   8'h04
`define OP_STATUS_RD   8'h05
`define OP_STATUS_WR   8'h01

// serial bit counter landmarks (count of rising edges already seen)
`define BIT_FIRST      5'h00
`define BIT_LAST_OP    5'h07
`define BIT_OP_DONE    5'h08
`define BIT_LAST_DATA  5'h0F
`define BIT_OVER       5'h10
`define BIT_SAT        5'h11
`define PHASE_LAST     3'h7

// status byte reset value and writable field positions of a written byte
`define STATUS_RESET   8'h00
`define WR_LOCK_POS    7
`define WR_GUARD_HI    3
`define WR_GUARD_LO    2

// block guard encodings and region bases
`define GUARD_NONE     2'h0
`define GUARD_QUARTER  2'h1
`define GUARD_HALF     2'h2
`define GUARD_ALL      2'h3
`define BASE_QUARTER   15'h6000
`define BASE_HALF      15'h4000

// system clock period in ns
`define CLK_PERIOD_NS  10
`endif
